/* File: ifr_cfg.svh */
// constants for the input function router: register offsets,
// reset values, selector codes and field positions.
// assumes it is included by its bare name, before the package.
`ifndef IFR_CFG_SVH
`define IFR_CFG_SVH

// ****************************************
// register offsets (word index on the port)
// ****************************************
`define IFR_ADDR_SELECT 4'h0
`define IFR_ADDR_ACTIVE 4'h1
`define IFR_ADDR_STATUS 4'h2
`define IFR_ADDR_TERMS 4'h3

// ****************************************
// reset values
// ****************************************
`define IFR_SELECT_RESET 16'h8888
`define IFR_ZERO_WORD 16'h0000
`define IFR_ZERO_TERMS 8'h00

// ****************************************
// selector digit positions and codes
// ****************************************
`define IFR_DIGIT_W 4
`define IFR_DIGITS 4
`define IFR_POS_DECEL 0
`define IFR_POS_LATCH1 1
`define IFR_POS_LATCH2 2
`define IFR_POS_LATCH3 3
`define IFR_DIGIT_MAX 4'h9
`define IFR_TERM_MAX 4'h7
`define IFR_DECEL_ON 4'h9
`define IFR_LATCH_INV_FIRST 4'hD
`define IFR_LATCH_INV_OFFSET 4'h8

// ****************************************
// status bit positions
// ****************************************
`define IFR_STAT_PENDING 0
`define IFR_STAT_REJECT 1

`endif

/* File: ifr_field.sv */
// field switches on the eight input terminals.
// assumes the bench sets the wanted pattern; pins move off the clock.
`timescale 1ns/1ps
`default_nettype none
// ********************
// switch model
// ********************
module ifr_field
(
    input wire ifr_pkg::ifr_terms_t want,
    output var ifr_pkg::ifr_terms_t term
);
    // contacts settle a while after the command, unrelated to the clock
    always
    begin
        term = want;
        @(want);
        #13;
    end
endmodule
`default_nettype wire

/* File: ifr_pkg.sv */
// shared types for the input function router.
// assumes ifr_cfg.svh is available on the include path.
`include "ifr_cfg.svh"

package ifr_pkg;
    // one selector digit
    typedef logic [3:0] ifr_digit_t;
    // the configuration and read data word
    typedef logic [15:0] ifr_word_t;
    // register index on the port
    typedef logic [3:0] ifr_addr_t;
    // the eight physical input terminals
    typedef logic [7:0] ifr_terms_t;
endpackage

/* File: ifr_router.sv */
// input function router: maps eight input terminals onto the
// homing deceleration switch and three external latch inputs.
// assumes terminals come from pins in another domain, and that
// RESTART comes from logic on CORE_CLK.
//
// Notes on behaviour
// - low digit 0-7 follows terminal 0-7
// - decel code 8 off, code 9 on
// - latch1 codes 5-7 follow terminals 5-7
// - latch1 codes B and C stay inactive
// - latch1 code D follows terminal 5 inverted
// - 16-bit word, decel digit 0-9, latch digits 0-F, reset 8888
// - digits 2 and 3 route latches 2, 3
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"

module ifr_router
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic RESTART,
    input wire ifr_pkg::ifr_terms_t IN_TERM,
    input wire ifr_pkg::ifr_addr_t REG_ADDR,
    input wire ifr_pkg::ifr_word_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output var ifr_pkg::ifr_word_t REG_RDATA,
    output var logic HOMING_DECEL_SWITCH,
    output var logic LATCH_INPUT_ONE,
    output var logic LATCH_INPUT_TWO,
    output var logic LATCH_INPUT_THREE
);
    import ifr_pkg::*;

    // ****************************************
    // declarations
    // ****************************************

    // first synchroniser stage, read only by the second
    ifr_terms_t term_meta;
    // second stage, the clean terminal levels
    ifr_terms_t term_sync;
    // word software writes; waits for a restart
    ifr_word_t input_select_word_four;
    // word the routing really uses
    ifr_word_t active_select;
    // sticky: a write held an out-of-range digit
    logic write_rejected;
    // combinational routing results
    logic next_decel;
    logic next_latch_one;
    logic next_latch_two;
    logic next_latch_three;
    // combinational read data
    ifr_word_t next_rdata;

    // ****************************************
    // helper functions
    // ****************************************

    // picks selector digit n out of a word
    function automatic ifr_digit_t get_digit
    (
        input ifr_word_t word,
        input int n
    );
        get_digit = word[n*`IFR_DIGIT_W +: `IFR_DIGIT_W];
    endfunction

    // true when the decel digit is one of its ten codes; the latch
    // digits use the whole 0-F table, so any value of theirs is legal
    function automatic logic word_in_range
    (
        input ifr_word_t word
    );
        logic ok;
        ok = 1'b1;
        if (get_digit(word, `IFR_POS_DECEL) > `IFR_DIGIT_MAX)
        begin
            ok = 1'b0;
        end
        word_in_range = ok;
    endfunction

    // decel routing: terminal, forced off or forced on
    function automatic logic route_decel
    (
        input ifr_digit_t sel,
        input ifr_terms_t terms
    );
        logic res;
        res = 1'b0;
        if (sel <= `IFR_TERM_MAX)
        begin
            // follow the chosen terminal while it is on
            res = terms[sel[2:0]];
        end
        else if (sel == `IFR_DECEL_ON)
        begin
            // held active whatever the pins do
            res = 1'b1;
        end
        else
        begin
            // code 8 holds the function inactive
            res = 1'b0;
        end
        route_decel = res;
    endfunction

    // latch routing, shared by all three latch functions
    function automatic logic route_latch
    (
        input ifr_digit_t sel,
        input ifr_terms_t terms
    );
        logic res;
        ifr_digit_t idx;
        res = 1'b0;
        idx = sel - `IFR_LATCH_INV_OFFSET;
        if (sel <= `IFR_TERM_MAX)
        begin
            // terminal n drives the latch while on
            res = terms[sel[2:0]];
        end
        else if (sel >= `IFR_LATCH_INV_FIRST)
        begin
            // inverted sense, code D maps to terminal 5
            res = ~terms[idx[2:0]];
        end
        else
        begin
            // codes 8 to C hold the latch inactive
            res = 1'b0;
        end
        route_latch = res;
    endfunction

    // ****************************************
    // terminal synchroniser
    // ****************************************

    // two flops per pin; glitches shorter than a cycle may
    // still pass, so no debounce is implied here
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            term_meta <= `IFR_ZERO_TERMS;
            term_sync <= `IFR_ZERO_TERMS;
        end
        else if (CLK_EN)
        begin
            term_meta <= IN_TERM;
            term_sync <= term_meta;
        end
    end

    // ****************************************
    // configuration word
    // ****************************************

    // software copy; an out-of-range write is dropped whole
    // rather than clamped, so a typo never half-applies
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            // factory default puts every selector at 8
            input_select_word_four <= `IFR_SELECT_RESET;
        end
        else if (CLK_EN)
        begin
            if (REG_WR && REG_ADDR == `IFR_ADDR_SELECT)
            begin
                // a decel digit above 9 refuses the write
                if (word_in_range(REG_WDATA))
                begin
                    input_select_word_four <= REG_WDATA;
                end
            end
        end
    end

    // ****************************************
    // active routing word
    // ****************************************

    // the pins keep the old routing until a restart, so a
    // running axis never sees its homing switch move
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            active_select <= `IFR_SELECT_RESET;
        end
        else if (CLK_EN)
        begin
            if (RESTART)
            begin
                // take over the written word at restart
                active_select <= input_select_word_four;
            end
        end
    end

    // ****************************************
    // rejected write flag
    // ****************************************

    // sticky; cleared by writing 1 to its status bit, and a
    // new rejection in the same cycle wins over the clear
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            write_rejected <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (REG_WR && REG_ADDR == `IFR_ADDR_SELECT
                && !word_in_range(REG_WDATA))
            begin
                // out-of-range setting refused
                write_rejected <= 1'b1;
            end
            else if (REG_WR && REG_ADDR == `IFR_ADDR_STATUS
                && REG_WDATA[`IFR_STAT_REJECT])
            begin
                write_rejected <= 1'b0;
            end
        end
    end

    // ****************************************
    // routing
    // ****************************************

    // each digit of the active word drives one function
    always_comb
    begin
        // homing decel from the lowest digit
        next_decel = route_decel(
            get_digit(active_select, `IFR_POS_DECEL), term_sync);
        // latch 1 from the second digit
        next_latch_one = route_latch(
            get_digit(active_select, `IFR_POS_LATCH1), term_sync);
        // latches 2 and 3 share the latch encoding
        next_latch_two = route_latch(
            get_digit(active_select, `IFR_POS_LATCH2), term_sync);
        next_latch_three = route_latch(
            get_digit(active_select, `IFR_POS_LATCH3), term_sync);
    end

    // function outputs straight from flops; costs one cycle
    // of latency but keeps the outputs glitch free
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            HOMING_DECEL_SWITCH <= 1'b0;
            LATCH_INPUT_ONE <= 1'b0;
            LATCH_INPUT_TWO <= 1'b0;
            LATCH_INPUT_THREE <= 1'b0;
        end
        else if (CLK_EN)
        begin
            HOMING_DECEL_SWITCH <= next_decel;
            LATCH_INPUT_ONE <= next_latch_one;
            LATCH_INPUT_TWO <= next_latch_two;
            LATCH_INPUT_THREE <= next_latch_three;
        end
    end

    // ****************************************
    // register read path
    // ****************************************

    // address decode; unmapped offsets read as zero
    always_comb
    begin
        next_rdata = `IFR_ZERO_WORD;
        if (REG_ADDR == `IFR_ADDR_SELECT)
        begin
            next_rdata = input_select_word_four;
        end
        else if (REG_ADDR == `IFR_ADDR_ACTIVE)
        begin
            // routing in use, may differ from the written word
            next_rdata = active_select;
        end
        else if (REG_ADDR == `IFR_ADDR_STATUS)
        begin
            // pending: written word not yet applied
            next_rdata[`IFR_STAT_PENDING] =
                (input_select_word_four != active_select);
            next_rdata[`IFR_STAT_REJECT] = write_rejected;
        end
        else if (REG_ADDR == `IFR_ADDR_TERMS)
        begin
            // synchronised terminal levels in the low byte
            next_rdata[7:0] = term_sync;
        end
        else
        begin
            next_rdata = `IFR_ZERO_WORD;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            REG_RDATA <= `IFR_ZERO_WORD;
        end
        else if (CLK_EN)
        begin
            if (REG_RD)
            begin
                REG_RDATA <= next_rdata;
            end
            else
            begin
                REG_RDATA <= `IFR_ZERO_WORD;
            end
        end
    end

endmodule

`default_nettype wire

/* File: ifr_router_props.sv */
// checker for the input function router, watching only its ports.
// assumes inputs stand still while CLK_EN is low, and a bind onto ifr_router.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"
// ********************
// port checker
// ********************
module ifr_router_props
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic RESTART,
    input wire ifr_pkg::ifr_terms_t IN_TERM,
    input wire ifr_pkg::ifr_addr_t REG_ADDR,
    input wire ifr_pkg::ifr_word_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire ifr_pkg::ifr_word_t REG_RDATA,
    input wire logic HOMING_DECEL_SWITCH,
    input wire logic LATCH_INPUT_ONE,
    input wire logic LATCH_INPUT_TWO,
    input wire logic LATCH_INPUT_THREE
);
    import ifr_pkg::*;
    ifr_word_t sel; // mirror of the written word
    ifr_word_t act; // mirror of the routing in use
    logic [2:0] age; // edges since reset, saturating
    function automatic logic ok(ifr_word_t w);
        // latch digits use the whole 0-F table; only decel is range checked
        return w[3:0] < 4'hA;
    endfunction
    function automatic logic dec_f(ifr_digit_t d, ifr_terms_t t);
        return d < 4'h8 ? t[d[2:0]] : d == 4'h9;
    endfunction
    // codes d..f fold onto terminals 5..7 through the low three bits
    function automatic logic lat_f(ifr_digit_t d, ifr_terms_t t);
        if (d < 4'h8)
            return t[d[2:0]];
        return d > 4'hC ? !t[d[2:0]] : 1'b0;
    endfunction
    // mirror registers; a bad write is dropped whole
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel <= `IFR_SELECT_RESET;
            act <= `IFR_SELECT_RESET;
            age <= 3'h0;
        end
        else if (CLK_EN)
        begin
            if (REG_WR && REG_ADDR == `IFR_ADDR_SELECT && ok(REG_WDATA))
                sel <= REG_WDATA;
            if (RESTART)
                act <= sel;
            if (age != 3'h4)
                age <= age + 3'h1;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_rd(ifr_addr_t a);
        CLK_EN && REG_RD && REG_ADDR == a;
    endsequence
    // sync chain must be refilled before routing can be judged
    sequence s_settled;
        age == 3'h4 && CLK_EN;
    endsequence
    a_decel_route: assert property (s_settled |-> HOMING_DECEL_SWITCH ==
        dec_f($past(act[3:0]), $past(IN_TERM, 3))) else $error("decel routing wrong");
    a_latch_one: assert property (s_settled |-> LATCH_INPUT_ONE ==
        lat_f($past(act[7:4]), $past(IN_TERM, 3))) else $error("latch one routing wrong");
    a_latch_two: assert property (s_settled |-> LATCH_INPUT_TWO ==
        lat_f($past(act[11:8]), $past(IN_TERM, 3))) else $error("latch two routing wrong");
    a_latch_three: assert property (s_settled |-> LATCH_INPUT_THREE ==
        lat_f($past(act[15:12]), $past(IN_TERM, 3))) else $error("latch three routing wrong");
    a_read_select: assert property (s_rd(`IFR_ADDR_SELECT) |=>
        REG_RDATA == $past(sel)) else $error("select readback wrong");
    a_read_active: assert property (s_rd(`IFR_ADDR_ACTIVE) |=>
        REG_RDATA == $past(act)) else $error("active readback wrong");
    a_read_gap: assert property (CLK_EN && !REG_RD |=> REG_RDATA == `IFR_ZERO_WORD)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property (CLK_EN && REG_RD && REG_ADDR > `IFR_ADDR_TERMS
        |=> REG_RDATA == `IFR_ZERO_WORD) else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(RST_N) |-> REG_RDATA == `IFR_ZERO_WORD &&
        !HOMING_DECEL_SWITCH && !LATCH_INPUT_ONE) else $error("outputs live after reset");
endmodule
bind ifr_router ifr_router_props chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .RESTART(RESTART), .IN_TERM(IN_TERM), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .HOMING_DECEL_SWITCH(HOMING_DECEL_SWITCH), .LATCH_INPUT_ONE(LATCH_INPUT_ONE),
    .LATCH_INPUT_TWO(LATCH_INPUT_TWO), .LATCH_INPUT_THREE(LATCH_INPUT_THREE));
`default_nettype wire

/* File: input_function_router_tb.sv */
// self-checking bench for the input function router.
// assumes the checker is bound; CLK_EN drops only in the freeze scenario.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"
// ********************
// bench
// ********************
module input_function_router_tb;
    import ifr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic restart = 1'b0;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ifr_addr_t reg_addr = 4'h0;
    ifr_word_t reg_wdata = 16'h0000;
    ifr_terms_t want = 8'h00; // pattern asked of the switches
    ifr_terms_t in_term;
    ifr_word_t reg_rdata;
    logic hom, l1, l2, l3;
    int error_cnt = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    ifr_field sw (.want(want), .term(in_term));
    ifr_router dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .RESTART(restart),
        .IN_TERM(in_term), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .HOMING_DECEL_SWITCH(hom),
        .LATCH_INPUT_ONE(l1), .LATCH_INPUT_TWO(l2), .LATCH_INPUT_THREE(l3));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input ifr_addr_t a, input ifr_word_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data are looked at in their single cycle
    task automatic rd(input ifr_addr_t a, input ifr_word_t exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic rst_pulse;
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
    endtask
    // five edges cover the sync chain and the output flop
    task automatic fn(input logic [3:0] exp);
        repeat (5) @(posedge clk);
        #1 chk({12'h000, hom, l1, l2, l3}, {12'h000, exp});
    endtask
    task automatic t_reset;
        want <= 8'hFF;
        fn(4'h0);
        rd(`IFR_ADDR_SELECT, 16'h8888);
        rd(4'h9, 16'h0000);
        rd(`IFR_ADDR_TERMS, 16'h00FF);
        rd(`IFR_ADDR_STATUS, 16'h0000);
    endtask
    task automatic t_decel;
        logic e;
        for (int n = 0; n < 10; n++)
        begin
            wr(`IFR_ADDR_SELECT, {12'h888, 4'(n)});
            rst_pulse();
            e = (n == 9);
            want <= 8'h01 << n;
            fn({n < 8 || e, 3'h0});
            want <= ~(8'h01 << n);
            fn({e, 3'h0});
        end
    endtask
    task automatic t_latch;
        for (int n = 0; n < 8; n++)
        begin
            wr(`IFR_ADDR_SELECT, {4'(n), 4'(n), 4'(n), 4'h8});
            rst_pulse();
            want <= 8'h01 << n;
            fn(4'h7);
            want <= ~(8'h01 << n);
            fn(4'h0);
        end
    endtask
    // a new word waits for restart; the old routing keeps working
    task automatic t_pending;
        wr(`IFR_ADDR_SELECT, 16'h8889);
        want <= 8'h00;
        fn(4'h0);
        rd(`IFR_ADDR_ACTIVE, 16'h7778);
        rst_pulse();
        fn(4'h8);
        rd(`IFR_ADDR_ACTIVE, 16'h8889);
    endtask
    // latch codes above 9: fixed off, and inverted terminals 5 to 7
    task automatic t_codes;
        wr(`IFR_ADDR_SELECT, 16'hDBD8);
        rst_pulse();
        want <= 8'hDF;
        fn(4'h5);
        want <= 8'h20;
        fn(4'h0);
        wr(`IFR_ADDR_SELECT, 16'hFEC8);
        rst_pulse();
        want <= 8'h3F;
        fn(4'h3);
        want <= 8'hC0;
        fn(4'h0);
    endtask
    task automatic t_reject;
        wr(`IFR_ADDR_SELECT, 16'h888A);
        rd(`IFR_ADDR_SELECT, 16'hFEC8);
        rd(`IFR_ADDR_STATUS, 16'h0002);
        wr(`IFR_ADDR_STATUS, 16'h0002);
        wr(`IFR_ADDR_SELECT, 16'h9999);
        rd(`IFR_ADDR_SELECT, 16'h9999);
        rd(`IFR_ADDR_STATUS, 16'h0001);
    endtask
    // with the enable low, a write and a restart must both be lost
    task automatic t_freeze;
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`IFR_ADDR_SELECT, 16'h8881);
        rst_pulse();
        @(posedge clk);
        clk_en <= 1'b1;
        rd(`IFR_ADDR_SELECT, 16'h9999);
        rd(`IFR_ADDR_ACTIVE, 16'hFEC8);
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_decel();
        t_latch();
        t_pending();
        t_codes();
        t_reject();
        t_freeze();
        stop_test();
    end
    // the run needs well under a millisecond
    initial
    begin
        #1_000_000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
